// ===== core/chg_pkg.sv
package chg_pkg;

  // register addresses on the register port
  localparam logic [7:0] ADDR_CHARGER_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h09;
  localparam logic [7:0] ADDR_INPUT_REG_STATUS = 8'h0A;
  localparam logic [7:0] ADDR_RESET_IDENTITY = 8'h0B;

  // writable bit positions
  localparam int VMASK_BIT = 1;
  localparam int IMASK_BIT = 0;
  localparam int REGRST_BIT = 7;

  // reset values and fixed read values
  localparam logic MASK_DEFAULT = 1'b0;
  localparam logic REGRST_DEFAULT = 1'b0;
  localparam logic RESERVED_BIT = 1'b0;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_STD_HOST = 3'h1,
    SRC_CHG_HOST = 3'h2,
    SRC_DEDICATED = 3'h3,
    SRC_UNLISTED = 3'h4,
    SRC_UNKNOWN = 3'h5,
    SRC_NONSTD = 3'h6,
    SRC_OTG = 3'h7
  } src_type_t;

  typedef enum logic [1:0] {
    PH_DISABLED = 2'h0,
    PH_PRECHARGE = 2'h1,
    PH_FAST = 2'h2,
    PH_DONE = 2'h3
  } phase_t;

  typedef enum logic [1:0] {
    CF_NORMAL = 2'h0,
    CF_INPUT = 2'h1,
    CF_THERMAL = 2'h2,
    CF_TIMER = 2'h3
  } chg_fault_t;

  typedef enum logic [2:0] {
    TZ_NORMAL = 3'h0,
    TZ_WARM = 3'h2,
    TZ_COOL = 3'h3,
    TZ_COLD = 3'h5,
    TZ_HOT = 3'h6
  } temp_zone_t;

endpackage

// ===== core/stat_if.sv
`timescale 1ns/100ps
`default_nettype none
interface stat_if;
  import chg_pkg::*;
  src_type_t input_source_type;
  phase_t charge_phase;
  logic power_good_flag;
  logic thermal_regulating_flag;
  logic system_min_regulating_flag;
  logic watchdog_fault;
  logic boost_fault;
  chg_fault_t charge_fault_code;
  logic battery_overvoltage_fault;
  temp_zone_t battery_temperature_zone;
  logic good_input_attached;
  logic input_voltage_limiting_flag;
  logic input_current_limiting_flag;
  logic topoff_timer_counting;
  logic adapter_overvoltage_flag;

  modport src (
    output input_source_type, charge_phase, power_good_flag,
    output thermal_regulating_flag, system_min_regulating_flag,
    output watchdog_fault, boost_fault, charge_fault_code,
    output battery_overvoltage_fault, battery_temperature_zone,
    output good_input_attached, input_voltage_limiting_flag,
    output input_current_limiting_flag, topoff_timer_counting,
    output adapter_overvoltage_flag
  );
  modport dst (
    input input_source_type, charge_phase, power_good_flag,
    input thermal_regulating_flag, system_min_regulating_flag,
    input watchdog_fault, boost_fault, charge_fault_code,
    input battery_overvoltage_fault, battery_temperature_zone,
    input good_input_attached, input_voltage_limiting_flag,
    input input_current_limiting_flag, topoff_timer_counting,
    input adapter_overvoltage_flag
  );
endinterface
`default_nettype wire

// ===== core/event_pulse.sv
`timescale 1ns/100ps
`default_nettype none
// one-cycle pulse on the rising edge of a level, unless masked
module event_pulse (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // event
  input wire logic level,
  input wire logic mask,
  output logic pulse
);
  logic level_ff;
  wire rise = level & ~level_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= level;
    end
  end

  assign pulse = rise & ~mask;
endmodule
`default_nettype wire

// ===== core/status_encode.sv
`timescale 1ns/100ps
`default_nettype none
module status_encode
  import chg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // live conditions from the analog side
  input wire logic [2:0] src_type_raw,
  input wire logic [1:0] phase_raw,
  input wire logic supply_in_range,
  input wire logic supply_weak,
  input wire logic thermal_reg_active,
  input wire logic vbat_below_sysmin,
  input wire logic sysmin_regulated,
  input wire logic watchdog_expired,
  input wire logic otg_overload,
  input wire logic input_ovp,
  input wire logic battery_too_low,
  input wire logic boost_blocked_other,
  input wire logic input_weak_fault,
  input wire logic thermal_shutdown,
  input wire logic safety_timer_expired,
  input wire logic battery_overvoltage_detect,
  input wire logic [2:0] temp_zone_raw,
  input wire logic buck_mode,
  input wire logic input_attached,
  input wire logic vin_regulating,
  input wire logic iin_regulating,
  input wire logic topoff_counting,
  input wire logic adapter_ovp,
  // encoded, registered fields
  stat_if.src st
);
  // the unlisted source code is folded into no input
  wire src_type_t src_enc = (src_type_raw == SRC_UNLISTED) ? SRC_NONE :
                            src_type_t'(src_type_raw);
  // input fault outranks thermal shutdown, which outranks the timer
  wire chg_fault_t cf_enc = (input_ovp | input_weak_fault) ? CF_INPUT :
                            thermal_shutdown ? CF_THERMAL :
                            safety_timer_expired ? CF_TIMER :
                            CF_NORMAL;
  wire cool_ok = (temp_zone_raw != TZ_COOL) | buck_mode;
  wire zone_listed = (temp_zone_raw == TZ_WARM) |
                     (temp_zone_raw == TZ_COOL) |
                     (temp_zone_raw == TZ_COLD) |
                     (temp_zone_raw == TZ_HOT);
  wire temp_zone_t tz_enc = (zone_listed & cool_ok) ?
                            temp_zone_t'(temp_zone_raw) :
                            TZ_NORMAL;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.input_source_type <= SRC_NONE;
      st.charge_phase <= PH_DISABLED;
      st.power_good_flag <= 1'b0;
      st.thermal_regulating_flag <= 1'b0;
      st.system_min_regulating_flag <= 1'b0;
      st.watchdog_fault <= 1'b0;
      st.boost_fault <= 1'b0;
      st.charge_fault_code <= CF_NORMAL;
      st.battery_overvoltage_fault <= 1'b0;
      st.battery_temperature_zone <= TZ_NORMAL;
      st.good_input_attached <= 1'b0;
      st.input_voltage_limiting_flag <= 1'b0;
      st.input_current_limiting_flag <= 1'b0;
      st.topoff_timer_counting <= 1'b0;
      st.adapter_overvoltage_flag <= 1'b0;
    end else begin
      st.input_source_type <= src_enc;
      st.charge_phase <= phase_t'(phase_raw);
      st.power_good_flag <= supply_in_range & ~supply_weak;
      st.thermal_regulating_flag <= thermal_reg_active;
      st.system_min_regulating_flag <=
        vbat_below_sysmin & sysmin_regulated;
      st.watchdog_fault <= watchdog_expired;
      st.boost_fault <= otg_overload | input_ovp | battery_too_low |
                        boost_blocked_other;
      st.charge_fault_code <= cf_enc;
      st.battery_overvoltage_fault <= battery_overvoltage_detect;
      // refreshed every cycle, reads never touch it
      st.battery_temperature_zone <= tz_enc;
      st.good_input_attached <= input_attached;
      st.input_voltage_limiting_flag <= vin_regulating;
      st.input_current_limiting_flag <= iin_regulating;
      st.topoff_timer_counting <= topoff_counting;
      st.adapter_overvoltage_flag <= adapter_ovp;
    end
  end
endmodule
`default_nettype wire

// ===== core/charger_status_fault_regs.sv
`timescale 1ns/100ps
`default_nettype none
module charger_status_fault_regs
  import chg_pkg::*;
#(
  // identity values, arbitrary
  parameter logic [3:0] PART_NUMBER = 4'hA,
  parameter logic MAKER_PART = 1'b1,
  parameter logic [1:0] DEVICE_REVISION = 2'h2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // live conditions
  input wire logic [2:0] src_type_raw,
  input wire logic [1:0] phase_raw,
  input wire logic supply_in_range,
  input wire logic supply_weak,
  input wire logic thermal_reg_active,
  input wire logic vbat_below_sysmin,
  input wire logic sysmin_regulated,
  input wire logic watchdog_expired,
  input wire logic otg_overload,
  input wire logic input_ovp,
  input wire logic battery_too_low,
  input wire logic boost_blocked_other,
  input wire logic input_weak_fault,
  input wire logic thermal_shutdown,
  input wire logic safety_timer_expired,
  input wire logic battery_overvoltage_detect,
  input wire logic [2:0] temp_zone_raw,
  input wire logic buck_mode,
  input wire logic input_attached,
  input wire logic vin_regulating,
  input wire logic iin_regulating,
  input wire logic topoff_counting,
  input wire logic adapter_ovp,
  // events and register-reset effects
  output logic vin_event_pulse,
  output logic iin_event_pulse,
  output logic regs_default_pulse,
  output logic safety_timer_restart
);

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire srst_n = rst_sync_ff;

  stat_if st ();

  status_encode u_encode (
    .clk(mclk),
    .rst_n(srst_n),
    .src_type_raw(src_type_raw),
    .phase_raw(phase_raw),
    .supply_in_range(supply_in_range),
    .supply_weak(supply_weak),
    .thermal_reg_active(thermal_reg_active),
    .vbat_below_sysmin(vbat_below_sysmin),
    .sysmin_regulated(sysmin_regulated),
    .watchdog_expired(watchdog_expired),
    .otg_overload(otg_overload),
    .input_ovp(input_ovp),
    .battery_too_low(battery_too_low),
    .boost_blocked_other(boost_blocked_other),
    .input_weak_fault(input_weak_fault),
    .thermal_shutdown(thermal_shutdown),
    .safety_timer_expired(safety_timer_expired),
    .battery_overvoltage_detect(battery_overvoltage_detect),
    .temp_zone_raw(temp_zone_raw),
    .buck_mode(buck_mode),
    .input_attached(input_attached),
    .vin_regulating(vin_regulating),
    .iin_regulating(iin_regulating),
    .topoff_counting(topoff_counting),
    .adapter_ovp(adapter_ovp),
    .st(st.src)
  );

  // writable state, then the registered read data and read valid
  logic vmask_ff;
  logic imask_ff;
  logic regrst_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  // write decode; only the writable bits of 0x0A and 0x0B have storage,
  // every other write lands nowhere
  wire wr_inreg = reg_wr & (reg_addr == ADDR_INPUT_REG_STATUS);
  wire wr_rstid = reg_wr & (reg_addr == ADDR_RESET_IDENTITY);
  wire regrst_req = wr_rstid & reg_wdata[REGRST_BIT];
  // the reset acts in the cycle after the write, while the bit reads as set
  wire regrst_fire = regrst_ff;

  wire nxt_vmask = regrst_fire ? MASK_DEFAULT :
                   wr_inreg ? reg_wdata[VMASK_BIT] : vmask_ff;
  wire nxt_imask = regrst_fire ? MASK_DEFAULT :
                   wr_inreg ? reg_wdata[IMASK_BIT] : imask_ff;
  // a new request in the clearing cycle wins over the self-clear
  wire nxt_regrst = regrst_req ? 1'b1 :
                    regrst_fire ? REGRST_DEFAULT : regrst_ff;

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      vmask_ff <= MASK_DEFAULT;
      imask_ff <= MASK_DEFAULT;
      regrst_ff <= REGRST_DEFAULT;
    end else begin
      vmask_ff <= nxt_vmask;
      imask_ff <= nxt_imask;
      regrst_ff <= nxt_regrst;
    end
  end

  assign regs_default_pulse = regrst_fire;
  assign safety_timer_restart = regrst_fire;

  // event pulses
  event_pulse u_vin_evt (
    .clk(mclk),
    .rst_n(srst_n),
    .level(st.input_voltage_limiting_flag),
    .mask(vmask_ff),
    .pulse(vin_event_pulse)
  );

  event_pulse u_iin_evt (
    .clk(mclk),
    .rst_n(srst_n),
    .level(st.input_current_limiting_flag),
    .mask(imask_ff),
    .pulse(iin_event_pulse)
  );

  // read images
  wire [7:0] img_charger = {st.input_source_type, st.charge_phase,
                            st.power_good_flag, st.thermal_regulating_flag,
                            st.system_min_regulating_flag};
  wire [7:0] img_fault = {st.watchdog_fault, st.boost_fault,
                          st.charge_fault_code,
                          st.battery_overvoltage_fault,
                          st.battery_temperature_zone};
  wire [7:0] img_inreg = {st.good_input_attached,
                          st.input_voltage_limiting_flag,
                          st.input_current_limiting_flag, RESERVED_BIT,
                          st.topoff_timer_counting,
                          st.adapter_overvoltage_flag,
                          vmask_ff, imask_ff};
  wire [7:0] img_rstid = {regrst_ff, PART_NUMBER, MAKER_PART,
                          DEVICE_REVISION};
  wire [7:0] rd_mux = (reg_addr == ADDR_CHARGER_STATUS) ? img_charger :
                      (reg_addr == ADDR_FAULT_STATUS) ? img_fault :
                      (reg_addr == ADDR_INPUT_REG_STATUS) ? img_inreg :
                      (reg_addr == ADDR_RESET_IDENTITY) ? img_rstid :
                      RDATA_UNMAPPED;

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      rdata_ff <= RDATA_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!srst_n);

  chk_src_never_unlisted: assert property (
    st.input_source_type != SRC_UNLISTED)
    else $error("unlisted source type reported");

  chk_src_follows_raw: assert property (
    (src_type_raw != SRC_UNLISTED) |=>
      (st.input_source_type == $past(src_type_raw)))
    else $error("source type not reported");

  chk_power_good: assert property (
    ##1 st.power_good_flag == $past(supply_in_range & ~supply_weak))
    else $error("power good flag wrong");

  chk_sysmin_flag: assert property (
    ##1 st.system_min_regulating_flag ==
      $past(vbat_below_sysmin & sysmin_regulated))
    else $error("sysmin flag wrong");

  chk_boost_fault: assert property (
    (otg_overload | input_ovp | battery_too_low | boost_blocked_other)
      |=> st.boost_fault)
    else $error("boost fault missed");

  chk_fault_input_first: assert property (
    (input_ovp | input_weak_fault) |=> st.charge_fault_code == CF_INPUT)
    else $error("input fault not reported");

  chk_fault_timer: assert property (
    (safety_timer_expired & ~input_ovp & ~input_weak_fault &
     ~thermal_shutdown) |=> st.charge_fault_code == CF_TIMER)
    else $error("timer fault not reported");

  chk_cool_buck_only: assert property (
    (temp_zone_raw == TZ_COOL && !buck_mode) |=>
      st.battery_temperature_zone == TZ_NORMAL)
    else $error("cool reported outside buck");

  chk_zone_live: assert property (
    (temp_zone_raw == TZ_HOT) |=> st.battery_temperature_zone == TZ_HOT)
    else $error("zone not refreshed");

  chk_vmask_blocks: assert property (
    vmask_ff |-> !vin_event_pulse)
    else $error("masked voltage event pulsed");

  chk_ievt_pulse: assert property (
    (!imask_ff && $rose(st.input_current_limiting_flag)) |->
      iin_event_pulse ##1 !iin_event_pulse)
    else $error("current event pulse wrong");

  chk_regrst_effect: assert property (
    regrst_req |=> safety_timer_restart ##1
      (!vmask_ff && !imask_ff))
    else $error("register reset did not act");

  chk_regrst_clears: assert property (
    (regrst_ff && !regrst_req) |=> !regrst_ff)
    else $error("reset bit stuck");

  chk_status_write_ignored: assert property (
    (reg_wr && reg_addr == ADDR_CHARGER_STATUS && !regrst_fire) |=>
      $stable(vmask_ff) && $stable(imask_ff))
    else $error("status write changed state");

  chk_read_latency: assert property (
    (reg_rd && reg_addr == ADDR_RESET_IDENTITY && !regrst_ff) |=>
      reg_rvalid && reg_rdata[REGRST_BIT-1:0] ==
        {PART_NUMBER, MAKER_PART, DEVICE_REVISION})
    else $error("identity read wrong");

  chk_phase_follows: assert property (
    ##1 st.charge_phase == $past(phase_raw))
    else $error("charge phase not reported");

  chk_thermal_flag: assert property (
    ##1 st.thermal_regulating_flag == $past(thermal_reg_active))
    else $error("thermal flag wrong");

  chk_watchdog_flag: assert property (
    ##1 st.watchdog_fault == $past(watchdog_expired))
    else $error("watchdog fault wrong");

  chk_fault_thermal: assert property (
    (thermal_shutdown && !input_ovp && !input_weak_fault) |=>
      st.charge_fault_code == CF_THERMAL)
    else $error("thermal fault not reported");

  chk_battery_overvoltage_detect_flag: assert property (
    ##1 st.battery_overvoltage_fault == $past(battery_overvoltage_detect))
    else $error("battery fault wrong");

  chk_attached_flag: assert property (
    ##1 st.good_input_attached == $past(input_attached))
    else $error("input attached flag wrong");

  chk_vlim_flag: assert property (
    ##1 st.input_voltage_limiting_flag == $past(vin_regulating))
    else $error("voltage limiting flag wrong");

  chk_ilim_flag: assert property (
    ##1 st.input_current_limiting_flag == $past(iin_regulating))
    else $error("current limiting flag wrong");

  chk_topoff_flag: assert property (
    ##1 st.topoff_timer_counting == $past(topoff_counting))
    else $error("top-off flag wrong");

  chk_acov_flag: assert property (
    ##1 st.adapter_overvoltage_flag == $past(adapter_ovp))
    else $error("adapter over-voltage flag wrong");

  chk_vevt_pulse: assert property (
    (!vmask_ff && $rose(st.input_voltage_limiting_flag)) |->
      vin_event_pulse)
    else $error("voltage event pulse missing");

  chk_regrst_set_wins: assert property (
    (regrst_req && regrst_ff) |=> regrst_ff)
    else $error("new reset request lost");

  cov_regrst: cover property (regrst_req ##1 regs_default_pulse);
  cov_vin_evt: cover property (vin_event_pulse);
  cov_iin_masked: cover property (
    imask_ff && $rose(st.input_current_limiting_flag));
  cov_fault_read: cover property (
    reg_rd && reg_addr == ADDR_FAULT_STATUS ##1 reg_rvalid);

endmodule
`default_nettype wire

// ===== testbench/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input wire logic mclk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // released lines carry the inverse so a stale value never looks valid
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== testbench/charger_status_fault_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module charger_status_fault_regs_tb;
  import chg_pkg::*;
  // identity values, arbitrary
  localparam logic [3:0] PN = 4'h9;
  localparam logic MK = 1'b1;
  localparam logic [1:0] RV = 2'h2;
  localparam logic [7:0] ID_BYTE = {1'b0, PN, MK, RV};
  logic mclk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic vin_event_pulse;
  logic iin_event_pulse;
  logic regs_default_pulse;
  logic safety_timer_restart;
  // all one-bit live conditions, packed so probes can set them at once
  logic [19:0] lv;
  logic [2:0] src;
  logic [1:0] ph;
  logic [2:0] zone;
  int err_total;
  int checks;

  host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  charger_status_fault_regs #(.PART_NUMBER(PN), .MAKER_PART(MK),
    .DEVICE_REVISION(RV)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .src_type_raw(src), .phase_raw(ph),
    .supply_in_range(lv[0]), .supply_weak(lv[1]),
    .thermal_reg_active(lv[2]), .vbat_below_sysmin(lv[3]),
    .sysmin_regulated(lv[4]), .watchdog_expired(lv[5]),
    .otg_overload(lv[6]), .input_ovp(lv[7]), .battery_too_low(lv[8]),
    .boost_blocked_other(lv[9]), .input_weak_fault(lv[10]),
    .thermal_shutdown(lv[11]), .safety_timer_expired(lv[12]),
    .battery_overvoltage_detect(lv[13]), .temp_zone_raw(zone),
    .buck_mode(lv[14]), .input_attached(lv[15]),
    .vin_regulating(lv[16]), .iin_regulating(lv[17]),
    .topoff_counting(lv[18]), .adapter_ovp(lv[19]),
    .vin_event_pulse(vin_event_pulse), .iin_event_pulse(iin_event_pulse),
    .regs_default_pulse(regs_default_pulse),
    .safety_timer_restart(safety_timer_restart));

  always #12.5 mclk = ~mclk;

  task automatic finish_test();
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_host.read_byte(a, d, ok);
    cmp({7'h00, ok}, 8'h01);
    cmp(d & m, e);
  endtask

  // status lags the live inputs by one edge, the read lands two later
  task automatic probe(input logic [19:0] v, input logic [7:0] a,
                       input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    lv <= v;
    rd_chk(a, m, e);
  endtask

  task automatic t_ident();
    rd_chk(ADDR_INPUT_REG_STATUS, 8'hFF, 8'h00);
    rd_chk(ADDR_RESET_IDENTITY, 8'hFF, ID_BYTE);
    u_host.write_byte(ADDR_RESET_IDENTITY, 8'h7F);
    rd_chk(ADDR_RESET_IDENTITY, 8'hFF, ID_BYTE);
    rd_chk(8'h0C, 8'hFF, RDATA_UNMAPPED);
    rd_chk(8'h07, 8'hFF, RDATA_UNMAPPED);
  endtask

  task automatic t_source();
    logic [2:0] es;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      src <= 3'(i);
      ph <= 2'(i);
      es = (i == 4) ? 3'h0 : 3'(i);
      rd_chk(ADDR_CHARGER_STATUS, 8'hF8, {es, 2'(i), 3'h0});
    end
  endtask

  task automatic t_stat08();
    probe(20'h00001, ADDR_CHARGER_STATUS, 8'h07, 8'h04);
    probe(20'h00003, ADDR_CHARGER_STATUS, 8'h07, 8'h00);
    probe(20'h00004, ADDR_CHARGER_STATUS, 8'h07, 8'h02);
    probe(20'h00018, ADDR_CHARGER_STATUS, 8'h07, 8'h01);
    probe(20'h00008, ADDR_CHARGER_STATUS, 8'h07, 8'h00);
  endtask

  task automatic t_fault09();
    probe(20'h00000, ADDR_FAULT_STATUS, 8'hFF, 8'h00);
    probe(20'h00020, ADDR_FAULT_STATUS, 8'h80, 8'h80);
    for (int b = 6; b < 10; b++) begin
      probe(20'h1 << b, ADDR_FAULT_STATUS, 8'h40, 8'h40);
    end
    probe(20'h00400, ADDR_FAULT_STATUS, 8'h30, 8'h10);
    probe(20'h00800, ADDR_FAULT_STATUS, 8'h30, 8'h20);
    probe(20'h01000, ADDR_FAULT_STATUS, 8'h30, 8'h30);
    probe(20'h00C00, ADDR_FAULT_STATUS, 8'h30, 8'h10);
    probe(20'h02000, ADDR_FAULT_STATUS, 8'h08, 8'h08);
  endtask

  task automatic t_zone();
    logic [2:0] ez;
    for (int z = 0; z < 8; z++) begin
      @(posedge mclk);
      zone <= 3'(z);
      lv <= 20'h04000;
      ez = (z == 2 || z == 3 || z == 5 || z == 6) ? 3'(z) : 3'h0;
      rd_chk(ADDR_FAULT_STATUS, 8'h07, {5'h00, ez});
    end
    @(posedge mclk);
    zone <= 3'h3;
    // cool with buck off must read as no zone
    probe(20'h00000, ADDR_FAULT_STATUS, 8'h07, 8'h00);
  endtask

  task automatic t_stat0a();
    probe(20'h08000, ADDR_INPUT_REG_STATUS, 8'h80, 8'h80);
    probe(20'h10000, ADDR_INPUT_REG_STATUS, 8'h40, 8'h40);
    probe(20'h20000, ADDR_INPUT_REG_STATUS, 8'h20, 8'h20);
    probe(20'h40000, ADDR_INPUT_REG_STATUS, 8'h08, 8'h08);
    probe(20'h80000, ADDR_INPUT_REG_STATUS, 8'h04, 8'h04);
    probe(20'h00000, ADDR_INPUT_REG_STATUS, 8'hFF, 8'h00);
    u_host.write_byte(ADDR_CHARGER_STATUS, 8'hFF);
    u_host.write_byte(ADDR_FAULT_STATUS, 8'hFF);
    u_host.write_byte(ADDR_INPUT_REG_STATUS, 8'hFC);
    // source and phase still hold on-the-go and terminated
    rd_chk(ADDR_CHARGER_STATUS, 8'hFF, 8'hF8);
    rd_chk(ADDR_FAULT_STATUS, 8'hFF, 8'h00);
    rd_chk(ADDR_INPUT_REG_STATUS, 8'hFF, 8'h00);
  endtask

  task automatic t_event(input int b, input logic m);
    int n;
    int at;
    logic p;
    n = 0;
    at = 0;
    u_host.write_byte(ADDR_INPUT_REG_STATUS,
      {6'h00, m & (b == 16), m & (b == 17)});
    @(posedge mclk);
    lv <= lv | (20'h1 << b);
    for (int k = 1; k <= 6; k++) begin
      @(posedge mclk);
      #1;
      p = (b == 16) ? vin_event_pulse : iin_event_pulse;
      if (p === 1'b1) begin
        n++;
        at = k;
      end
    end
    @(posedge mclk);
    lv <= lv & ~(20'h1 << b);
    cmp(8'(n), m ? 8'h00 : 8'h01);
    cmp(8'(at), m ? 8'h00 : 8'h01);
  endtask

  task automatic t_regrst();
    u_host.write_byte(ADDR_INPUT_REG_STATUS, 8'h03);
    rd_chk(ADDR_INPUT_REG_STATUS, 8'h03, 8'h03);
    u_host.write_byte(ADDR_RESET_IDENTITY, 8'h00);
    rd_chk(ADDR_INPUT_REG_STATUS, 8'h03, 8'h03);
    u_host.write_byte(ADDR_RESET_IDENTITY, 8'h80);
    #1;
    cmp({6'h00, regs_default_pulse, safety_timer_restart}, 8'h03);
    @(posedge mclk);
    #1;
    cmp({6'h00, regs_default_pulse, safety_timer_restart}, 8'h00);
    rd_chk(ADDR_INPUT_REG_STATUS, 8'h03, 8'h00);
    rd_chk(ADDR_RESET_IDENTITY, 8'hFF, ID_BYTE);
  endtask

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    lv = '0;
    src = 3'h0;
    ph = 2'h0;
    zone = 3'h0;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_ident();
    t_source();
    t_stat08();
    t_fault09();
    t_zone();
    t_stat0a();
    t_event(16, 1'b0);
    t_event(16, 1'b1);
    t_event(17, 1'b0);
    t_event(17, 1'b1);
    t_regrst();
    finish_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
